// ### inc/ccsr_defines.svh
// Constants for the machine, floating-point and loop CSR bank.
// Assumes a 12-bit CSR address space and 32-bit CSR data.
//
// Function
// - Read-only fields ignore every CSR write.
// - Writable fields keep the last written value.
// - Five sticky exception flags, upper bits zero.
// - Three-bit rounding mode field, upper bits zero.
// - Combined view: mode 7:5, flags 4:0.
// - Float CSRs exist only with float unit.
// - Loop addresses user read-only, bits 1:0 zero.
// - Loop counts 32-bit read-only, reset zero.
// - Float state field in status 14:13.
// - Float instruction except store marks dirty.
// - Previous privilege hardwired 11 without user.
// - Trap saves enable; return restores it.
// - Interrupt enables at 31:16, 11, 7, 3.
// - Trap base 256-byte aligned, 7:2 zero.
// - Trap mode bit 0, bit 1 zero.
// - Trap vector resets from boot base input.
// - Traps branch using trap base 31:8.
// - Return loads PC from exception PC.
`ifndef CCSR_DEFINES_SVH
`define CCSR_DEFINES_SVH

`define CCSR_A_FLAGS      12'h001
`define CCSR_A_RMODE      12'h002
`define CCSR_A_FCTRL      12'h003
`define CCSR_A_STATE      12'h300
`define CCSR_A_IRQEN      12'h304
`define CCSR_A_TVEC       12'h305
`define CCSR_A_SCRATCH    12'h340
`define CCSR_A_LP0_BEGIN  12'hCC0
`define CCSR_A_LP0_FINISH 12'hCC1
`define CCSR_A_LP0_COUNT  12'hCC2
`define CCSR_A_LP1_BEGIN  12'hCC4
`define CCSR_A_LP1_FINISH 12'hCC5
`define CCSR_A_LP1_COUNT  12'hCC6

`define CCSR_ST_DIRTY_SUM 31
`define CCSR_ST_FS_HI     14
`define CCSR_ST_FS_LO     13
`define CCSR_ST_PP_HI     12
`define CCSR_ST_PP_LO     11
`define CCSR_ST_PIE       7
`define CCSR_ST_IE        3
`define CCSR_FC_RM_HI     7
`define CCSR_FC_RM_LO     5
`define CCSR_TV_BASE_LO   8

`define CCSR_IRQEN_MASK   32'hFFFF0888
`define CCSR_STATE_RST    32'h00001800
`define CCSR_FS_DIRTY     2'h3
`define CCSR_FS_OFF       2'h0
`define CCSR_PRIV_M       2'h3
`define CCSR_PRIV_U       2'h0
`define CCSR_TV_MODE_RST  1'h1

`endif

// ### inc/ccsr_pkg.sv
// Types shared by the CSR bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ccsr_pkg;
	typedef logic [11:0] ccsr_addr_t;
	typedef logic [31:0] ccsr_word_t;
	typedef enum logic [1:0] {LP_BEGIN, LP_FINISH, LP_COUNT} ccsr_loop_fld_t;
endpackage : ccsr_pkg
`default_nettype wire

// ### inc/ccsr_sub_if.sv
// Carrier between the bank and its float and loop storage.
// Assumes one clock domain shared by all users.
`default_nettype none
interface ccsr_sub_if;
	import ccsr_pkg::*;
	logic                  flagsWe;
	logic [4:0]            flagsWdata;
	logic [4:0]            flagsAccrue;
	logic                  rmWe;
	logic [2:0]            rmWdata;
	logic [4:0]            flags;
	logic [2:0]            rm;
	logic                  lpWe;
	logic                  lpSel;
	ccsr_loop_fld_t        lpFld;
	ccsr_word_t            lpWdata;
	logic [1:0]            lpDecr;
	logic [1:0][31:0]      lpBegin;
	logic [1:0][31:0]      lpFinish;
	logic [1:0][31:0]      lpCount;
	modport bank (output flagsWe, flagsWdata, flagsAccrue, rmWe, rmWdata, lpWe, lpSel, lpFld, lpWdata,
		lpDecr, input flags, rm, lpBegin, lpFinish, lpCount);
	modport fp (input flagsWe, flagsWdata, flagsAccrue, rmWe, rmWdata, output flags, rm);
	modport loop (input lpWe, lpSel, lpFld, lpWdata, lpDecr, output lpBegin, lpFinish, lpCount);
endinterface : ccsr_sub_if
`default_nettype wire

// ### rtl/ccsr_fp_store.sv
// Single storage for the exception flags and rounding mode.
// Assumes the bank already gates writes by address.
`include "ccsr_defines.svh"
`default_nettype none
module ccsr_fp_store #(
	parameter int FLOAT_UNIT_PRESENT = 1
) (
	input  wire logic  clk,  // core clock
	input  wire logic  rstn, // async reset, low
	ccsr_sub_if.fp     sub   // write and view port
);
	import ccsr_pkg::*;

	generate
		if (FLOAT_UNIT_PRESENT == 1) begin : g_fp
			// Accrual wins over a write in the same cycle so no event is lost.
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) sub.flags <= 5'h00;
				else sub.flags <= (sub.flagsWe ? sub.flagsWdata : sub.flags) | sub.flagsAccrue;
			end
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) sub.rm <= 3'h0;
				else if (sub.rmWe) sub.rm <= sub.rmWdata;
			end
			flag_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
				|sub.flagsAccrue |=> ((sub.flags & $past(sub.flagsAccrue)) == $past(sub.flagsAccrue)))
				else $error("accrued flag lost");
		end else begin : g_nofp
			assign sub.flags = 5'h00;
			assign sub.rm    = 3'h0;
		end
	endgenerate
endmodule : ccsr_fp_store
`default_nettype wire

// ### rtl/ccsr_loop_regs.sv
// Hardware loop begin, finish and count registers.
// Assumes the loop controller alone updates them.
`default_nettype none
module ccsr_loop_regs #(
	parameter int CUSTOM_EXTENSION_ENABLE = 1,
	parameter int LOOPS                   = 2
) (
	input  wire logic  clk,  // core clock
	input  wire logic  rstn, // async reset, low
	ccsr_sub_if.loop   sub   // loop controller port
);
	import ccsr_pkg::*;

	generate
		for (genvar i = 0; i < LOOPS; i++) begin : g_lp
			if (CUSTOM_EXTENSION_ENABLE == 1) begin : g_on
				logic wrHere;
				assign wrHere = sub.lpWe && (sub.lpSel == 1'(i));
				always_ff @(posedge clk or negedge rstn) begin
					if (!rstn) begin
						sub.lpBegin[i]  <= 32'h00000000;
						sub.lpFinish[i] <= 32'h00000000;
					end else if (wrHere && sub.lpFld == LP_BEGIN) begin
						sub.lpBegin[i]  <= {sub.lpWdata[31:2], 2'h0};
					end else if (wrHere && sub.lpFld == LP_FINISH) begin
						sub.lpFinish[i] <= {sub.lpWdata[31:2], 2'h0};
					end
				end
				always_ff @(posedge clk or negedge rstn) begin
					if (!rstn) sub.lpCount[i] <= 32'h00000000;
					else if (wrHere && sub.lpFld == LP_COUNT) sub.lpCount[i] <= sub.lpWdata;
					else if (sub.lpDecr[i] && sub.lpCount[i] != 32'h00000000) sub.lpCount[i] <= sub.lpCount[i] - 32'h1;
				end
				cnt_dec_a: assert property (@(posedge clk) disable iff (!rstn)
					sub.lpDecr[i] && !wrHere && sub.lpCount[i] != 32'h0 |=> sub.lpCount[i] == $past(sub.lpCount[i]) - 32'h1)
					else $error("loop count did not step down");
			end else begin : g_off
				assign sub.lpBegin[i]  = 32'h00000000;
				assign sub.lpFinish[i] = 32'h00000000;
				assign sub.lpCount[i]  = 32'h00000000;
			end
		end
	endgenerate
endmodule : ccsr_loop_regs
`default_nettype wire

// ### rtl/ccsr_bank.sv
// Machine, floating-point and hardware-loop CSR bank.
// Assumes the pipeline presents one CSR access per cycle and trap events as pulses.
`include "ccsr_defines.svh"
`default_nettype none
module ccsr_bank #(
	parameter int FLOAT_UNIT_PRESENT      = 1,
	parameter int SHARED_INT_REGS         = 0,
	parameter int CUSTOM_EXTENSION_ENABLE = 1,
	parameter int USER_MODE_ENABLE        = 0
) (
	input  wire logic              clk,          // core clock
	input  wire logic              rstn,         // async reset, low
	input  wire ccsr_pkg::ccsr_addr_t csrAddr,   // CSR address
	input  wire logic              csrRe,        // read request
	input  wire logic              csrWe,        // write request
	input  wire ccsr_pkg::ccsr_word_t csrWdata,  // write data
	output ccsr_pkg::ccsr_word_t   csrRdata,     // read data, registered
	output logic                   csrRvalid,    // read data valid pulse
	output logic                   csrIllegal,   // access refused pulse
	input  wire logic              trapTake,     // exception or interrupt taken
	input  wire logic              trapIsIrq,    // trap is an interrupt
	input  wire logic [4:0]        trapCause,    // trap cause code
	input  wire logic              mretTake,     // trap return executed
	input  wire ccsr_pkg::ccsr_word_t mepcIn,    // saved exception PC
	output logic                   pcLoad,       // redirect pulse
	output ccsr_pkg::ccsr_word_t   pcTarget,     // redirect target
	input  wire logic              fpExec,       // float instruction executed
	input  wire logic              fpIsStore,    // that instruction is a store
	input  wire logic [4:0]        fpAccrue,     // flags raised by float unit
	output logic [2:0]             fpRoundMode,  // rounding mode to float unit
	input  wire logic              lpWe,         // loop controller write
	input  wire logic              lpSel,        // loop index
	input  wire ccsr_pkg::ccsr_loop_fld_t lpFld, // loop field
	input  wire ccsr_pkg::ccsr_word_t lpWdata,   // loop write data
	input  wire logic [1:0]        lpDecr,       // loop count step
	input  wire ccsr_pkg::ccsr_word_t bootTrapBase, // boot trap base
	output logic [31:0]            irqEnable,    // interrupt enables
	output logic                   irqGlobalEn   // global interrupt enable
);
	import ccsr_pkg::*;

	localparam logic FP_ON  = (FLOAT_UNIT_PRESENT == 1);
	localparam logic FS_ON  = FP_ON && (SHARED_INT_REGS == 0);
	localparam logic LP_ON  = (CUSTOM_EXTENSION_ENABLE == 1);
	// Reset image of the status word, named so that single fields can be selected from it.
	localparam ccsr_word_t STATE_RST = `CCSR_STATE_RST;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic csrMapped(input ccsr_addr_t a);
		case (a)
			`CCSR_A_FLAGS, `CCSR_A_RMODE, `CCSR_A_FCTRL: return FP_ON;
			`CCSR_A_STATE, `CCSR_A_IRQEN, `CCSR_A_TVEC, `CCSR_A_SCRATCH: return 1'b1;
			`CCSR_A_LP0_BEGIN, `CCSR_A_LP0_FINISH, `CCSR_A_LP0_COUNT,
			`CCSR_A_LP1_BEGIN, `CCSR_A_LP1_FINISH, `CCSR_A_LP1_COUNT: return LP_ON;
			default: return 1'b0;
		endcase
	endfunction : csrMapped

	function automatic logic csrReadOnly(input ccsr_addr_t a);
		return a[11:10] == 2'h3;
	endfunction : csrReadOnly

	logic rdOk;
	logic wrOk;
	logic wrHit;

	assign rdOk  = csrMapped(csrAddr);
	// Writes to the loop registers are refused whole, never partly applied.
	assign wrOk  = csrMapped(csrAddr) && !csrReadOnly(csrAddr);
	assign wrHit = csrWe && wrOk;

	// ----------------------------------------
	// Float and loop storage
	// ----------------------------------------
	ccsr_sub_if sub ();

	assign sub.flagsWe     = wrHit && (csrAddr == `CCSR_A_FLAGS || csrAddr == `CCSR_A_FCTRL);
	assign sub.flagsWdata  = csrWdata[4:0];
	assign sub.rmWe        = wrHit && (csrAddr == `CCSR_A_RMODE || csrAddr == `CCSR_A_FCTRL);
	assign sub.rmWdata     = (csrAddr == `CCSR_A_FCTRL) ? csrWdata[`CCSR_FC_RM_HI:`CCSR_FC_RM_LO]
		: csrWdata[2:0];
	assign sub.flagsAccrue = FP_ON ? fpAccrue : 5'h00;
	assign sub.lpWe        = lpWe;
	assign sub.lpSel       = lpSel;
	assign sub.lpFld       = lpFld;
	assign sub.lpWdata     = lpWdata;
	assign sub.lpDecr      = lpDecr;
	assign fpRoundMode     = sub.rm;

	ccsr_fp_store #(
		.FLOAT_UNIT_PRESENT (FLOAT_UNIT_PRESENT)
	) u_fp (
		.clk  (clk),
		.rstn (rstn),
		.sub  (sub.fp)
	);

	ccsr_loop_regs #(
		.CUSTOM_EXTENSION_ENABLE (CUSTOM_EXTENSION_ENABLE),
		.LOOPS                   (2)
	) u_loop (
		.clk  (clk),
		.rstn (rstn),
		.sub  (sub.loop)
	);

	// ----------------------------------------
	// Machine status
	// ----------------------------------------
	logic       ie;
	logic       pie;
	logic [1:0] fs;
	logic [1:0] pp;
	logic       stWr;

	// A trap or return in the same cycle as a status write takes precedence.
	assign stWr = wrHit && csrAddr == `CCSR_A_STATE && !trapTake && !mretTake;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ie  <= STATE_RST[`CCSR_ST_IE];
			pie <= STATE_RST[`CCSR_ST_PIE];
		end else if (trapTake) begin
			pie <= ie;
			ie  <= 1'b0;
		end else if (mretTake) begin
			ie  <= pie;
			pie <= 1'b1;
		end else if (stWr) begin
			ie  <= csrWdata[`CCSR_ST_IE];
			pie <= csrWdata[`CCSR_ST_PIE];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) fs <= `CCSR_FS_OFF;
		else if (!FS_ON) fs <= `CCSR_FS_OFF;
		else if (fpExec && !fpIsStore) fs <= `CCSR_FS_DIRTY;
		else if (stWr) fs <= csrWdata[`CCSR_ST_FS_HI:`CCSR_ST_FS_LO];
	end

	generate
		if (USER_MODE_ENABLE == 0) begin : g_mpp_fixed
			assign pp = `CCSR_PRIV_M;
		end else begin : g_mpp_rw
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) pp <= STATE_RST[`CCSR_ST_PP_HI:`CCSR_ST_PP_LO];
				else if (trapTake) pp <= `CCSR_PRIV_M;
				else if (mretTake) pp <= `CCSR_PRIV_U;
				else if (stWr) pp <= (csrWdata[`CCSR_ST_PP_HI:`CCSR_ST_PP_LO] == `CCSR_PRIV_M)
					? `CCSR_PRIV_M : `CCSR_PRIV_U;
			end
		end
	endgenerate

	ccsr_word_t stView;
	always_comb begin
		stView = 32'h00000000;
		stView[`CCSR_ST_DIRTY_SUM] = (fs == `CCSR_FS_DIRTY);
		stView[`CCSR_ST_FS_HI:`CCSR_ST_FS_LO] = fs;
		stView[`CCSR_ST_PP_HI:`CCSR_ST_PP_LO] = pp;
		stView[`CCSR_ST_PIE] = pie;
		stView[`CCSR_ST_IE] = ie;
	end
	assign irqGlobalEn = ie;

	// ----------------------------------------
	// Interrupt enables, scratch, trap vector
	// ----------------------------------------
	ccsr_word_t scratch;
	logic [23:0] tvBase;
	logic        tvMode;
	logic        tvBoot;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) irqEnable <= 32'h00000000;
		else if (wrHit && csrAddr == `CCSR_A_IRQEN) irqEnable <= csrWdata & `CCSR_IRQEN_MASK;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) scratch <= 32'h00000000;
		else if (wrHit && csrAddr == `CCSR_A_SCRATCH) scratch <= csrWdata;
	end

	// The boot base is a pin, so it is caught on the first edge after release.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tvBase <= 24'h000000;
			tvMode <= `CCSR_TV_MODE_RST;
			tvBoot <= 1'b1;
		end else if (tvBoot) begin
			tvBase <= bootTrapBase[31:`CCSR_TV_BASE_LO];
			tvMode <= `CCSR_TV_MODE_RST;
			tvBoot <= 1'b0;
		end else if (wrHit && csrAddr == `CCSR_A_TVEC) begin
			tvBase <= csrWdata[31:`CCSR_TV_BASE_LO];
			tvMode <= csrWdata[0];
		end
	end

	// ----------------------------------------
	// Trap redirect
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) pcLoad <= 1'b0;
		else pcLoad <= trapTake || mretTake;
	end

	// Vectored interrupts add cause times four; the offset never reaches bit 8.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) pcTarget <= 32'h00000000;
		else if (trapTake) pcTarget <= (tvMode && trapIsIrq) ? {tvBase, 1'b0, trapCause, 2'h0}
			: {tvBase, 8'h00};
		else if (mretTake) pcTarget <= mepcIn;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	ccsr_word_t rdView;
	always_comb begin
		case (csrAddr)
			`CCSR_A_FLAGS:      rdView = {27'h0, sub.flags};
			`CCSR_A_RMODE:      rdView = {29'h0, sub.rm};
			`CCSR_A_FCTRL:      rdView = {24'h0, sub.rm, sub.flags};
			`CCSR_A_STATE:      rdView = stView;
			`CCSR_A_IRQEN:      rdView = irqEnable;
			`CCSR_A_TVEC:       rdView = {tvBase, 6'h00, 1'b0, tvMode};
			`CCSR_A_SCRATCH:    rdView = scratch;
			`CCSR_A_LP0_BEGIN:  rdView = sub.lpBegin[0];
			`CCSR_A_LP0_FINISH: rdView = sub.lpFinish[0];
			`CCSR_A_LP0_COUNT:  rdView = sub.lpCount[0];
			`CCSR_A_LP1_BEGIN:  rdView = sub.lpBegin[1];
			`CCSR_A_LP1_FINISH: rdView = sub.lpFinish[1];
			`CCSR_A_LP1_COUNT:  rdView = sub.lpCount[1];
			default:            rdView = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			csrRdata   <= 32'h00000000;
			csrRvalid  <= 1'b0;
			csrIllegal <= 1'b0;
		end else begin
			csrRdata   <= (csrRe && rdOk) ? rdView : 32'h00000000;
			csrRvalid  <= csrRe && rdOk;
			csrIllegal <= (csrRe && !rdOk) || (csrWe && !wrOk);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	trap_saves_ie_a: assert property (@(posedge clk) disable iff (!rstn)
		trapTake |=> pie == $past(ie) && !ie)
		else $error("trap did not save interrupt enable");

	mret_restore_a: assert property (@(posedge clk) disable iff (!rstn)
		mretTake && !trapTake |=> ie == $past(pie))
		else $error("return did not restore interrupt enable");

	fs_dirty_a: assert property (@(posedge clk) disable iff (!rstn)
		fpExec && !fpIsStore |=> fs == (FS_ON ? `CCSR_FS_DIRTY : `CCSR_FS_OFF))
		else $error("float state not marked dirty");

	dirty_summary_a: assert property (@(posedge clk) disable iff (!rstn)
		stView[`CCSR_ST_DIRTY_SUM] == (stView[`CCSR_ST_FS_HI:`CCSR_ST_FS_LO] == 2'h3))
		else $error("dirty summary disagrees with float state");

	pp_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
		USER_MODE_ENABLE == 0 |-> stView[`CCSR_ST_PP_HI:`CCSR_ST_PP_LO] == 2'h3)
		else $error("previous privilege not hardwired");

	tvec_shape_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr) == `CCSR_A_TVEC |-> csrRdata[7:1] == 7'h00)
		else $error("trap vector low bits not zero");

	tvec_boot_a: assert property (@(posedge clk) disable iff (!rstn)
		tvBoot |=> tvBase == $past(bootTrapBase[31:8]) && tvMode && !tvBoot)
		else $error("trap vector not loaded from boot base");

	trap_branch_a: assert property (@(posedge clk) disable iff (!rstn)
		trapTake && !(tvMode && trapIsIrq) |=> pcLoad && pcTarget == {$past(tvBase), 8'h00})
		else $error("trap target wrong");

	mret_pc_a: assert property (@(posedge clk) disable iff (!rstn)
		mretTake && !trapTake |=> pcLoad && pcTarget == $past(mepcIn))
		else $error("return target wrong");

	irqen_mask_a: assert property (@(posedge clk) disable iff (!rstn)
		(irqEnable & ~`CCSR_IRQEN_MASK) == 32'h0)
		else $error("unimplemented enable bit set");

	ro_write_a: assert property (@(posedge clk) disable iff (!rstn)
		csrWe && csrReadOnly(csrAddr) |=> csrIllegal)
		else $error("read-only write not refused");

	fctrl_view_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr) == `CCSR_A_FCTRL |-> csrRdata == {24'h0, $past(sub.rm), $past(sub.flags)})
		else $error("combined float view differs");

	dirty_read_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr) == `CCSR_A_STATE |-> csrRdata[31] == (csrRdata[14:13] == 2'h3))
		else $error("dirty summary read wrong");

	flags_read_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr) == `CCSR_A_FLAGS |-> csrRdata[31:5] == 27'h0000000)
		else $error("flag register upper bits not zero");

	rmode_read_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr) == `CCSR_A_RMODE |-> csrRdata[31:3] == 29'h00000000)
		else $error("rounding mode upper bits not zero");

	fs_write_a: assert property (@(posedge clk) disable iff (!rstn)
		stWr && !(fpExec && !fpIsStore) |=> fs == (FS_ON ? $past(csrWdata[14:13]) : 2'h0))
		else $error("float state write wrong");

	scratch_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		wrHit && csrAddr == `CCSR_A_SCRATCH |=> scratch == $past(csrWdata))
		else $error("scratch write lost");

	irqen_write_a: assert property (@(posedge clk) disable iff (!rstn)
		wrHit && csrAddr == `CCSR_A_IRQEN |=> irqEnable == ($past(csrWdata) & `CCSR_IRQEN_MASK))
		else $error("interrupt enable write wrong");

	// The boot load owns the first edge, so a write there is not expected to land.
	tvec_write_a: assert property (@(posedge clk) disable iff (!rstn)
		wrHit && csrAddr == `CCSR_A_TVEC && !tvBoot
		|=> tvBase == $past(csrWdata[31:8]) && tvMode == $past(csrWdata[0]))
		else $error("trap vector write wrong");

	// Begin and finish addresses sit where address bit 1 is clear.
	loop_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		csrRvalid && $past(csrAddr[11:4]) == 8'hCC && !$past(csrAddr[1]) |-> csrRdata[1:0] == 2'h0)
		else $error("loop address low bits not zero");

	rm_write_a: assert property (@(posedge clk) disable iff (!rstn)
		sub.rmWe |=> sub.rm == $past(sub.rmWdata))
		else $error("rounding mode write lost");
endmodule : ccsr_bank
`default_nettype wire

// ### test/ccsr_pipe_model.sv
// Core pipeline model that issues one CSR read or write at a time.
// Assumes the bank registers its answer on the same edge that takes a request.
`default_nettype none
module ccsr_pipe_model (
	input  wire logic                 clk,        // core clock
	output ccsr_pkg::ccsr_addr_t      csrAddr,    // CSR address
	output logic                      csrRe,      // read request
	output logic                      csrWe,      // write request
	output ccsr_pkg::ccsr_word_t      csrWdata,   // write data
	input  wire ccsr_pkg::ccsr_word_t csrRdata,   // read data
	input  wire logic                 csrRvalid,  // read answer
	input  wire logic                 csrIllegal  // refusal
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccsr_pkg::*;

	initial begin
		csrAddr  = 12'h000;
		csrRe    = 1'b0;
		csrWe    = 1'b0;
		csrWdata = 32'h00000000;
	end

	// ----------------------------------------
	// Access
	// ----------------------------------------
	task automatic access(input logic wr, input ccsr_addr_t a, input ccsr_word_t d,
		output ccsr_word_t q, output logic ill, output logic ok);
		@(posedge clk);
		csrAddr  <= a;
		csrWdata <= d;
		csrRe    <= !wr;
		csrWe    <= wr;
		@(posedge clk);
		csrRe    <= 1'b0;
		csrWe    <= 1'b0;
		// Released lines show the inverse, so a stale value can never pass for a live one.
		csrAddr  <= ~a;
		csrWdata <= ~d;
		#1;
		q   = csrRdata;
		ill = csrIllegal;
		ok  = wr ? (csrRvalid === 1'b0) : ((csrRvalid ^ csrIllegal) === 1'b1);
	endtask : access
endmodule : ccsr_pipe_model
`default_nettype wire

// ### test/ccsr_bank_test.sv
// Self-checking bench for the CSR bank with its default parameters.
// Assumes the pipeline model and the shared defines header.
`include "ccsr_defines.svh"
`default_nettype none
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module ccsr_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ccsr_pkg::*;
	localparam ccsr_word_t BOOT = 32'h12345678;
	logic clk, rstn, csrRe, csrWe, csrRvalid, csrIllegal, trapTake, trapIsIrq, mretTake, pcLoad;
	logic fpExec, fpIsStore, lpWe, lpSel, irqGlobalEn;
	logic [4:0] trapCause, fpAccrue;
	logic [2:0] fpRoundMode;
	logic [1:0] lpDecr;
	logic [31:0] irqEnable;
	ccsr_addr_t csrAddr;
	ccsr_word_t csrWdata, csrRdata, mepcIn, pcTarget, lpWdata, bootTrapBase;
	ccsr_loop_fld_t lpFld;
	int miscompares, nCompared;

	ccsr_pipe_model pipe (.clk, .csrAddr, .csrRe, .csrWe, .csrWdata, .csrRdata, .csrRvalid, .csrIllegal);
	ccsr_bank DUT (.clk, .rstn, .csrAddr, .csrRe, .csrWe, .csrWdata, .csrRdata, .csrRvalid, .csrIllegal,
		.trapTake, .trapIsIrq, .trapCause, .mretTake, .mepcIn, .pcLoad, .pcTarget, .fpExec, .fpIsStore,
		.fpAccrue, .fpRoundMode, .lpWe, .lpSel, .lpFld, .lpWdata, .lpDecr, .bootTrapBase, .irqEnable,
		.irqGlobalEn);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		if (miscompares == 0 && nCompared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wr(input ccsr_addr_t a, input ccsr_word_t d, input logic expIll);
		ccsr_word_t q;
		logic ill, ok;
		pipe.access(1'b1, a, d, q, ill, ok);
		`CHK({ok, ill}, {1'b1, expIll})
	endtask : wr

	task automatic rd(input ccsr_addr_t a, input ccsr_word_t exp, input logic expIll);
		ccsr_word_t q;
		logic ill, ok;
		pipe.access(1'b0, a, 32'h00000000, q, ill, ok);
		`CHK({ok, ill, q}, {1'b1, expIll, exp})
	endtask : rd

	task automatic event_pulse(input logic isTrap, input logic irq, input logic [4:0] cause, input ccsr_word_t pc);
		@(posedge clk);
		trapTake  <= isTrap;
		mretTake  <= !isTrap;
		trapIsIrq <= irq;
		trapCause <= cause;
		@(posedge clk);
		trapTake <= 1'b0;
		mretTake <= 1'b0;
		#1;
		`CHK({pcLoad, pcTarget}, {1'b1, pc})
	endtask : event_pulse

	task automatic side_pulse(input logic fe, input logic st, input logic [4:0] acc, input logic lw,
		input logic sel, input ccsr_loop_fld_t fld, input ccsr_word_t d, input logic [1:0] dec);
		@(posedge clk);
		fpExec    <= fe;
		fpIsStore <= st;
		fpAccrue  <= acc;
		lpWe      <= lw;
		lpSel     <= sel;
		lpFld     <= fld;
		lpWdata   <= d;
		lpDecr    <= dec;
		@(posedge clk);
		fpExec   <= 1'b0;
		fpAccrue <= 5'h00;
		lpWe     <= 1'b0;
		lpDecr   <= 2'h0;
		#1;
	endtask : side_pulse

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		ccsr_addr_t ra[13] = '{`CCSR_A_FLAGS, `CCSR_A_RMODE, `CCSR_A_FCTRL, `CCSR_A_STATE, `CCSR_A_IRQEN,
			`CCSR_A_TVEC, `CCSR_A_SCRATCH, `CCSR_A_LP0_BEGIN, `CCSR_A_LP0_FINISH, `CCSR_A_LP0_COUNT,
			`CCSR_A_LP1_BEGIN, `CCSR_A_LP1_FINISH, `CCSR_A_LP1_COUNT};
		{rstn, trapTake, trapIsIrq, mretTake, fpExec, fpIsStore, lpWe, lpSel} = 8'h00;
		{trapCause, fpAccrue, lpDecr} = 12'h000;
		lpFld = LP_BEGIN;
		{mepcIn, lpWdata} = 64'h0;
		bootTrapBase = BOOT;
		miscompares = 0;
		nCompared = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			rd(ra[i], (i == 3) ? 32'h00001800 : (i == 5) ? {BOOT[31:8], 8'h01} : 32'h0, 1'b0);
		end
		wr(`CCSR_A_SCRATCH, 32'hFFFFFFFF, 1'b0);
		rd(`CCSR_A_SCRATCH, 32'hFFFFFFFF, 1'b0);
		wr(`CCSR_A_IRQEN, 32'hFFFFFFFF, 1'b0);
		`CHK(irqEnable, 32'hFFFF0888)
		rd(`CCSR_A_IRQEN, 32'hFFFF0888, 1'b0);
		wr(`CCSR_A_TVEC, 32'hFFFFFFFF, 1'b0);
		rd(`CCSR_A_TVEC, 32'hFFFFFF01, 1'b0);
		wr(`CCSR_A_FLAGS, 32'hFFFFFFFF, 1'b0);
		rd(`CCSR_A_FLAGS, 32'h0000001F, 1'b0);
		wr(`CCSR_A_RMODE, 32'hFFFFFFFF, 1'b0);
		rd(`CCSR_A_RMODE, 32'h00000007, 1'b0);
		rd(`CCSR_A_FCTRL, 32'h000000FF, 1'b0);
		wr(`CCSR_A_FCTRL, 32'hFFFFFFA5, 1'b0);
		rd(`CCSR_A_FLAGS, 32'h00000005, 1'b0);
		rd(`CCSR_A_RMODE, 32'h00000005, 1'b0);
		wr(`CCSR_A_FLAGS, 32'h0, 1'b0);
		for (int m = 0; m < 8; m++) begin
			wr(`CCSR_A_RMODE, m, 1'b0);
			`CHK(fpRoundMode, 3'(m))
			rd(`CCSR_A_FCTRL, {24'h0, 3'(m), 5'h00}, 1'b0);
		end
		wr(`CCSR_A_STATE, 32'hFFFFFFFF, 1'b0);
		rd(`CCSR_A_STATE, 32'h80007888, 1'b0);
		`CHK(irqGlobalEn, 1'b1)
		wr(`CCSR_A_STATE, 32'h0, 1'b0);
		rd(`CCSR_A_STATE, 32'h00001800, 1'b0);
		side_pulse(1'b1, 1'b1, 5'h05, 1'b0, 1'b0, LP_BEGIN, 32'h0, 2'h0);
		rd(`CCSR_A_STATE, 32'h00001800, 1'b0);
		side_pulse(1'b1, 1'b0, 5'h10, 1'b0, 1'b0, LP_BEGIN, 32'h0, 2'h0);
		rd(`CCSR_A_STATE, 32'h80007800, 1'b0);
		rd(`CCSR_A_FLAGS, 32'h00000015, 1'b0);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b1, 1'b0, LP_BEGIN, 32'h12345677, 2'h0);
		rd(`CCSR_A_LP0_BEGIN, 32'h12345674, 1'b0);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b1, 1'b1, LP_FINISH, 32'h00000FFF, 2'h0);
		rd(`CCSR_A_LP1_FINISH, 32'h00000FFC, 1'b0);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b1, 1'b0, LP_COUNT, 32'h00000001, 2'h0);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b0, 1'b0, LP_COUNT, 32'h0, 2'h1);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b0, 1'b0, LP_COUNT, 32'h0, 2'h1);
		rd(`CCSR_A_LP0_COUNT, 32'h0, 1'b0);
		side_pulse(1'b0, 1'b0, 5'h0, 1'b1, 1'b1, LP_COUNT, 32'hFFFFFFFF, 2'h0);
		wr(`CCSR_A_LP1_COUNT, 32'h00000005, 1'b1);
		rd(`CCSR_A_LP1_COUNT, 32'hFFFFFFFF, 1'b0);
		wr(12'h123, 32'h1, 1'b1);
		rd(12'h123, 32'h0, 1'b1);
		wr(`CCSR_A_TVEC, 32'h00001200, 1'b0);
		wr(`CCSR_A_STATE, 32'h00000008, 1'b0);
		event_pulse(1'b1, 1'b0, 5'h03, 32'h00001200);
		`CHK(irqGlobalEn, 1'b0)
		rd(`CCSR_A_STATE, 32'h00001880, 1'b0);
		mepcIn <= 32'h00000400;
		event_pulse(1'b0, 1'b0, 5'h00, 32'h00000400);
		rd(`CCSR_A_STATE, 32'h00001888, 1'b0);
		wr(`CCSR_A_TVEC, 32'h00001201, 1'b0);
		event_pulse(1'b1, 1'b1, 5'h07, 32'h0000121C);
		event_pulse(1'b1, 1'b0, 5'h07, 32'h00001200);
		tally_and_finish();
	end
endmodule : ccsr_bank_test
`default_nettype wire
